// ### src/auth_device.sv
/*
 * Device end: byte register file, 384-byte two-bank shared memory with
 * auto-advancing address, and the challenge-response engine.
 * Assumes the controller follows the order below and that the otp bytes
 * come from on-chip logic on sys_clk.
 */
// Behaviour
// - command 0x35 with id, 0x36 without
// - digest is single-block sha-256
// - block is secret, challenge, constant data
// - id replaces 64 constant bits when chosen
// - 16 secret and id bits: metal plus otp
// - host writes challenge to bytes 0x00-0x13
// - digest overwrites memory bytes 0x00-0x1f
// - secret never readable on the link
// - operation ignores pass or fail outcome
// - host enables, loads, starts, waits, reads, disables
// - start self-clears, done event raised
// - host loads command and challenge before start
// - host memory writes need write enable set
// - 384 bytes, bank bit picks bank
// - crossing 0xff sets bank bit
// - index gives burst start location
// - address saturates at 0x17f
// - data port reads advance memory address
`timescale 1ns/1ps
`include "auth_map.svh"
module auth_device #(
   parameter int             MEM_BYTES    = 384,
   parameter logic [159:0]   SECRET_FIXED =
      160'h0123456789abcdef0123456789abcdef01234567,
   parameter logic [7:0]     SECRET_METAL = 8'h5a,
   parameter logic [63:0]    ID_FIXED     = 64'h1122334455667788, // arbitrary
   parameter logic [7:0]     ID_METAL     = 8'h3c,                // arbitrary
   parameter logic [191:0]   CONST_DATA   = {6{32'h0f1e2d3c}}
) (
   input  wire logic   sys_clk,
   input  wire logic   rst,
   auth_link_if.dev    lk,
   input  wire logic [7:0] otp_secret_byte,
   input  wire logic [7:0] otp_id_byte,
   output logic        engine_busy
);
   localparam logic [8:0] LAST = 9'(MEM_BYTES - 1);

   // bank 1 must exist and the address stays 9 bits wide
   if (MEM_BYTES < 257 || MEM_BYTES > 512) begin : g_chk
      $error("MEM_BYTES must lie in 257..512");
   end

   auth_pkg::dev_st_t s, n;
   logic [7:0]   mem [MEM_BYTES];
   logic         mem_we;
   logic [8:0]   mem_wa;
   logic [7:0]   mem_wd;
   logic [8:0]   rd_a;
   logic [7:0]   rd_byte;
   logic         take;
   logic         cmd_ok;
   logic [159:0] secret;
   logic [63:0]  uid;
   logic [191:0] konst;
   logic [511:0] block;
   logic         core_busy;
   logic         core_done;
   logic [255:0] digest;

   // block assembly; secret only ever feeds the engine
   always_comb begin
      secret = {SECRET_FIXED[159:16], SECRET_METAL,
                otp_secret_byte};
      uid    = {ID_FIXED[63:16], ID_METAL, otp_id_byte};
      konst  = s.with_id ? {uid, CONST_DATA[127:0]} : CONST_DATA;
      block  = {secret, s.chal, konst};
   end

   sha256_core u_core (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (s.go),
      .block   (block),
      .busy    (core_busy),
      .done    (core_done),
      .digest  (digest)
   );

   assign rd_a    = (s.st == auth_pkg::D_LOAD) ? 9'(s.cnt) : s.addr;
   assign rd_byte = mem[rd_a];
   assign cmd_ok  = (s.cmd == `CMD_MAC_WITH_ID) ||
                    (s.cmd == `CMD_MAC_NO_ID);

   // next address of a burst: climbs into bank 1, then sticks at the top
   function automatic logic [8:0] next_addr(input logic [8:0] a);
      next_addr = (a == LAST) ? a : a + 9'h001;
   endfunction

   always_comb begin
      n       = s;
      n.ack   = 1'b0;
      n.done  = 1'b0;
      n.go    = 1'b0;
      mem_we  = 1'b0;
      mem_wa  = s.addr;
      mem_wd  = lk.wdata;
      take    = lk.req && !s.ack;
      // engine; result is not judged here, only stored
      case (s.st)
         auth_pkg::D_IDLE: begin
            if (s.start && s.en && cmd_ok) begin
               n.st      = auth_pkg::D_LOAD;
               n.cnt     = 6'd0;
               n.with_id = (s.cmd == `CMD_MAC_WITH_ID);
            end else if (s.start) begin
               n.start = 1'b0; // reserved code or engine disabled
            end
         end
         auth_pkg::D_LOAD: begin
            n.chal = {s.chal[151:0], rd_byte};
            n.cnt  = s.cnt + 6'd1;
            if (s.cnt == 6'(`CHAL_BYTES - 1)) begin
               n.st = auth_pkg::D_HASH;
               n.go = 1'b1;
            end
         end
         auth_pkg::D_HASH: begin
            if (core_done) begin
               n.st  = auth_pkg::D_STORE;
               n.cnt = 6'd0;
            end
         end
         default: begin
            mem_we = 1'b1;
            mem_wa = 9'(s.cnt);
            mem_wd = digest[(31 - s.cnt) * 8 +: 8];
            n.cnt  = s.cnt + 6'd1;
            if (s.cnt == 6'(`DIGEST_BYTES - 1)) begin
               n.st    = auth_pkg::D_IDLE;
               n.start = 1'b0;
               n.done  = 1'b1;
            end
         end
      endcase
      // register access from the link, answered one cycle later
      if (take) begin
         n.ack = 1'b1;
         if (lk.we) begin
            if (lk.addr == `HASH_COMMAND_OFS) begin
               n.cmd = lk.wdata;
            end else if (lk.addr == `AUTH_CONFIG_OFS) begin
               n.en = lk.wdata[`CFG_EN_BIT];
               // a running hash keeps its start bit until it ends
               if (s.st == auth_pkg::D_IDLE) begin
                  n.start = lk.wdata[`CFG_START_BIT];
               end
            end else if (lk.addr == `MEMORY_CONTROL_OFS) begin
               n.wren = lk.wdata[`MCTL_WREN_BIT];
               n.addr = {lk.wdata[`MCTL_BANK_BIT], s.idx};
            end else if (lk.addr == `MEMORY_INDEX_OFS) begin
               n.idx  = lk.wdata;
               n.addr = {s.addr[8], lk.wdata};
            end else if (lk.addr == `MEMORY_DATA_OFS) begin
               // engine owns the memory while it runs; a late host
               // write must not cancel a digest byte being stored
               if (s.st == auth_pkg::D_IDLE) begin
                  mem_we = s.wren;
               end
               n.addr = next_addr(s.addr);
            end
         end else begin
            // no path here ever carries the secret
            if (lk.addr == `HASH_COMMAND_OFS) begin
               n.rdata = s.cmd;
            end else if (lk.addr == `AUTH_CONFIG_OFS) begin
               n.rdata = {6'h00, s.en, s.start};
            end else if (lk.addr == `MEMORY_CONTROL_OFS) begin
               n.rdata = {6'h00, s.wren, s.addr[8]};
            end else if (lk.addr == `MEMORY_INDEX_OFS) begin
               n.rdata = s.idx;
            end else if (lk.addr == `MEMORY_DATA_OFS) begin
               n.rdata = rd_byte;
               n.addr  = next_addr(s.addr);
            end else begin
               n.rdata = 8'h00;
            end
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s     <= '0;
         s.cmd <= `HASH_COMMAND_RST;
         s.idx <= `MEMORY_INDEX_RST;
      end else begin
         s <= n;
      end
   end

   // shared memory, no reset: contents are undefined until written
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign lk.rdata    = s.rdata;
   assign lk.ack      = s.ack;
   assign lk.done     = s.done;
   assign engine_busy = (s.st != auth_pkg::D_IDLE) || core_busy;
endmodule

// ### src/auth_host.sv
/*
 * Controller end: apb slave registers, a fixed step sequence that drives the
 * device link through one authentication, and a level interrupt.
 * Assumes the device answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps
`include "auth_map.svh"
module auth_host (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   auth_link_if.host        lk
);
   auth_pkg::host_st_t s, n;
   logic        acc;
   logic [1:0]  iset;
   logic [1:0]  iclr;
   logic        st_we;
   logic [7:0]  st_addr;
   logic [7:0]  st_wdata;
   logic [5:0]  k;
   logic [5:0]  rk;

   // step table of the step about to be presented; keyed on the next
   // step so a new request follows its ack without repeating the old one
   always_comb begin
      k        = 6'd0;
      st_we    = 1'b1;
      st_addr  = `MEMORY_DATA_OFS;
      st_wdata = 8'h00;
      if (n.step == 6'd0) begin
         st_addr  = `AUTH_CONFIG_OFS;
         st_wdata = 8'(1 << `CFG_EN_BIT);
      end else if (n.step == 6'd1) begin
         st_addr  = `MEMORY_CONTROL_OFS;
         st_wdata = 8'(1 << `MCTL_WREN_BIT);
      end else if (n.step == 6'd2 || n.step == 6'd27) begin
         st_addr  = `MEMORY_INDEX_OFS;
      end else if (n.step < `STEP_CMD) begin
         k        = n.step - `STEP_LOAD0;
         st_wdata = s.chal[159 - 8*k -: 8];
      end else if (n.step == `STEP_CMD) begin
         st_addr  = `HASH_COMMAND_OFS;
         st_wdata = s.cmd;
      end else if (n.step == `STEP_START) begin
         st_addr  = `AUTH_CONFIG_OFS;
         st_wdata = 8'((1 << `CFG_EN_BIT) | (1 << `CFG_START_BIT));
      end else if (n.step == 6'd26) begin
         st_addr  = `MEMORY_CONTROL_OFS; // bank 0, writes locked
      end else if (n.step < `STEP_LAST) begin
         st_we    = 1'b0;
      end else begin
         st_addr  = `AUTH_CONFIG_OFS; // disable again
      end
   end

   always_comb begin
      n      = s;
      iset   = 2'b00;
      iclr   = 2'b00;
      rk     = 6'd0;
      acc    = psel && penable;
      // sequencer; req stays up across steps since ack is one cycle
      case (s.st)
         auth_pkg::H_IDLE: begin
            n.req = 1'b0;
         end
         auth_pkg::H_REQ: begin
            if (lk.ack) begin
               if (!s.we) begin
                  rk = s.step - `STEP_RD0;
                  n.dig[255 - 8*rk -: 8] = lk.rdata;
               end
               n.step = s.step + 6'd1;
               if (s.step == `STEP_LAST) begin
                  n.st      = auth_pkg::H_IDLE;
                  n.busy    = 1'b0;
                  n.req     = 1'b0;
                  iset[`ISTAT_SEQ_BIT] = 1'b1;
               end else if (s.step + 6'd1 == `STEP_WAIT) begin
                  n.st  = auth_pkg::H_WAIT;
                  n.req = 1'b0;
               end
            end
         end
         default: begin
            if (lk.done) begin
               n.step = s.step + 6'd1;
               n.st   = auth_pkg::H_REQ;
               n.req  = 1'b1;
            end
         end
      endcase
      if (lk.done) begin
         iset[`ISTAT_DONE_BIT] = 1'b1;
      end
      // apb: one wait state, write lands on the ready edge
      n.pready = acc && !s.pready;
      if (acc && !s.pready) begin
         n.prdata = 32'h0000_0000;
         if (paddr == `CTRL_OFS || paddr == `STAT_OFS) begin
            n.prdata = {31'h0, s.busy};
         end else if (paddr == `CMD_OFS) begin
            n.prdata = {24'h0, s.cmd};
         end else if (paddr == `ISTAT_OFS) begin
            n.prdata = {30'h0, s.ist};
         end else if (paddr == `IMASK_OFS) begin
            n.prdata = {30'h0, s.imask};
         end else if (paddr[11:5] == `CHAL_PAGE && paddr[4:2] < 3'd5) begin
            n.prdata = s.chal[159 - 32*paddr[4:2] -: 32];
         end else if (paddr[11:5] == `DIG_PAGE) begin
            n.prdata = s.dig[255 - 32*paddr[4:2] -: 32];
         end
      end
      if (acc && s.pready && pwrite) begin
         if (paddr == `CTRL_OFS) begin
            if (pwdata[0] && !s.busy) begin
               n.busy = 1'b1;
               n.step = 6'd0;
               n.st   = auth_pkg::H_REQ;
               n.req  = 1'b1;
            end
         end else if (paddr == `CMD_OFS) begin
            n.cmd = pwdata[7:0];
         end else if (paddr == `ISTAT_OFS) begin
            iclr = pwdata[1:0];
         end else if (paddr == `IMASK_OFS) begin
            n.imask = pwdata[1:0];
         end else if (paddr[11:5] == `CHAL_PAGE && paddr[4:2] < 3'd5) begin
            n.chal[159 - 32*paddr[4:2] -: 32] = pwdata;
         end
      end
      // a set arriving with its clear wins
      n.ist = (s.ist & ~iclr) | iset;
      // link outputs follow the step about to be presented
      if (n.req) begin
         n.we    = st_we;
         n.addr  = st_addr;
         n.wdata = st_wdata;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s     <= '0;
         s.cmd <= `HOST_CMD_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata   = s.prdata;
   assign pready   = s.pready;
   assign pslverr  = 1'b0;
   assign irq      = |(s.ist & s.imask);
   assign lk.req   = s.req;
   assign lk.we    = s.we;
   assign lk.addr  = s.addr;
   assign lk.wdata = s.wdata;
endmodule

// ### src/auth_link_if.sv
/*
 * Register link between controller and device: byte request, one-cycle ack,
 * and the done event of the engine.
 * Assumes both ends run on the same sys_clk.
 */
`timescale 1ns/1ps
interface auth_link_if ();
   logic       req;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       ack;
   logic       done;

   modport dev  (input req, we, addr, wdata, output rdata, ack, done);
   modport host (output req, we, addr, wdata, input rdata, ack, done);
endinterface

// ### src/auth_map.svh
/*
 * Register offsets, field positions, reset values and sequence counts of
 * the challenge-response engine and of its controller.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef AUTH_MAP_SVH
`define AUTH_MAP_SVH

// device register offsets, one byte each
`define HASH_COMMAND_OFS   8'hf0
`define AUTH_CONFIG_OFS    8'hf1
`define MEMORY_CONTROL_OFS 8'hf2
`define MEMORY_INDEX_OFS   8'hf3
`define MEMORY_DATA_OFS    8'hf4
// device reset values
`define HASH_COMMAND_RST   8'h00
`define MEMORY_INDEX_RST   8'h00
// command codes
`define CMD_MAC_WITH_ID    8'h35
`define CMD_MAC_NO_ID      8'h36
// field positions
`define CFG_START_BIT      0
`define CFG_EN_BIT         1
`define MCTL_BANK_BIT      0
`define MCTL_WREN_BIT      1
// engine counts
`define CHAL_BYTES         20
`define DIGEST_BYTES       32
`define SHA_ROUNDS         64
// controller registers on apb
`define CTRL_OFS           12'h000
`define CMD_OFS            12'h004
`define STAT_OFS           12'h008
`define ISTAT_OFS          12'h00c
`define IMASK_OFS          12'h010
`define CHAL_PAGE          7'h01
`define DIG_PAGE           7'h02
`define ISTAT_DONE_BIT     0
`define ISTAT_SEQ_BIT      1
`define HOST_CMD_RST       8'h35
// controller step numbers on the link
`define STEP_LOAD0         6'd3
`define STEP_CMD           6'd23
`define STEP_START         6'd24
`define STEP_WAIT          6'd25
`define STEP_RD0           6'd28
`define STEP_LAST          6'd60

`endif

// ### src/auth_pkg.sv
/*
 * Types shared by the engine, the device end and the controller end.
 * Assumes nothing beyond the map header.
 */
package auth_pkg;

   typedef enum logic [1:0] {D_IDLE, D_LOAD, D_HASH, D_STORE} dev_state_t;
   typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} host_state_t;

   typedef struct packed {
      logic              busy;
      logic              done;
      logic [6:0]        rnd;
      logic [15:0][31:0] w;
      logic [7:0][31:0]  v;
      logic [255:0]      digest;
   } core_st_t;

   typedef struct packed {
      logic [7:0]   cmd;
      logic         en;
      logic         start;
      logic         wren;
      logic [8:0]   addr;
      logic [7:0]   idx;
      logic [7:0]   rdata;
      logic         ack;
      logic         done;
      dev_state_t   st;
      logic [5:0]   cnt;
      logic [159:0] chal;
      logic         with_id;
      logic         go;
   } dev_st_t;

   typedef struct packed {
      host_state_t  st;
      logic         busy;
      logic [5:0]   step;
      logic [7:0]   cmd;
      logic [159:0] chal;
      logic [255:0] dig;
      logic [1:0]   ist;
      logic [1:0]   imask;
      logic [31:0]  prdata;
      logic         pready;
      logic         req;
      logic         we;
      logic [7:0]   addr;
      logic [7:0]   wdata;
   } host_st_t;

endpackage

// ### src/sha256_core.sv
/*
 * Single-block sha-256 compression, one round per clock.
 * Assumes the caller supplies an already formed 512-bit block and holds it
 * stable only for the cycle of start.
 */
`timescale 1ns/1ps
`include "auth_map.svh"
module sha256_core (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [511:0] block,
   output logic              busy,
   output logic              done,
   output logic [255:0]      digest
);
   localparam logic [63:0][31:0] K = {
      32'hc67178f2, 32'hbef9a3f7, 32'ha4506ceb, 32'h90befffa, 32'h8cc70208,
      32'h84c87814, 32'h78a5636f, 32'h748f82ee, 32'h682e6ff3, 32'h5b9cca4f,
      32'h4ed8aa4a, 32'h391c0cb3, 32'h34b0bcb5, 32'h2748774c, 32'h1e376c08,
      32'h19a4c116, 32'h106aa070, 32'hf40e3585, 32'hd6990624, 32'hd192e819,
      32'hc76c51a3, 32'hc24b8b70, 32'ha81a664b, 32'ha2bfe8a1, 32'h92722c85,
      32'h81c2c92e, 32'h766a0abb, 32'h650a7354, 32'h53380d13, 32'h4d2c6dfc,
      32'h2e1b2138, 32'h27b70a85, 32'h14292967, 32'h06ca6351, 32'hd5a79147,
      32'hc6e00bf3, 32'hbf597fc7, 32'hb00327c8, 32'ha831c66d, 32'h983e5152,
      32'h76f988da, 32'h5cb0a9dc, 32'h4a7484aa, 32'h2de92c6f, 32'h240ca1cc,
      32'h0fc19dc6, 32'hefbe4786, 32'he49b69c1, 32'hc19bf174, 32'h9bdc06a7,
      32'h80deb1fe, 32'h72be5d74, 32'h550c7dc3, 32'h243185be, 32'h12835b01,
      32'hd807aa98, 32'hab1c5ed5, 32'h923f82a4, 32'h59f111f1, 32'h3956c25b,
      32'he9b5dba5, 32'hb5c0fbcf, 32'h71374491, 32'h428a2f98};
   localparam logic [7:0][31:0] IV = {
      32'h5be0cd19, 32'h1f83d9ab, 32'h9b05688c, 32'h510e527f,
      32'ha54ff53a, 32'h3c6ef372, 32'hbb67ae85, 32'h6a09e667};

   function automatic logic [31:0] ror(input logic [31:0] x, input int n);
      ror = (x >> n) | (x << (32 - n));
   endfunction

   auth_pkg::core_st_t s, n;
   logic [31:0] t1, t2, wn;

   // one compression round; v[0]..v[7] hold a..h
   always_comb begin
      n = s;
      n.done = 1'b0;
      t1 = s.v[7] + (ror(s.v[4], 6) ^ ror(s.v[4], 11) ^ ror(s.v[4], 25))
         + ((s.v[4] & s.v[5]) ^ (~s.v[4] & s.v[6]))
         + K[s.rnd[5:0]] + s.w[0];
      t2 = (ror(s.v[0], 2) ^ ror(s.v[0], 13) ^ ror(s.v[0], 22))
         + ((s.v[0] & s.v[1]) ^ (s.v[0] & s.v[2]) ^ (s.v[1] & s.v[2]));
      wn = (ror(s.w[14], 17) ^ ror(s.w[14], 19) ^ (s.w[14] >> 10)) + s.w[9]
         + (ror(s.w[1], 7) ^ ror(s.w[1], 18) ^ (s.w[1] >> 3)) + s.w[0];
      if (!s.busy) begin
         if (start) begin
            n.busy = 1'b1;
            n.rnd  = 7'h00;
            n.v    = IV;
            for (int j = 0; j < 16; j++) begin
               n.w[j] = block[511 - 32*j -: 32];
            end
         end
      end else if (s.rnd == 7'(`SHA_ROUNDS)) begin
         // final add of the initial hash value
         for (int j = 0; j < 8; j++) begin
            n.digest[255 - 32*j -: 32] = IV[j] + s.v[j];
         end
         n.busy = 1'b0;
         n.done = 1'b1;
      end else begin
         n.v    = {s.v[6:4], s.v[3] + t1, s.v[2:0], t1 + t2};
         n.w    = {wn, s.w[15:1]};
         n.rnd  = s.rnd + 7'h01;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign busy   = s.busy;
   assign done   = s.done;
   assign digest = s.digest;
endmodule

// ### tb/auth_link_props.sv
/*
 * checker of the link between controller and device: ack and done pulses,
 * request hold, read data hold, start to done latency.
 * assumes one clock sys_clk and a synchronous active-high rst.
 */
`timescale 1ns/1ps
module auth_link_props (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       req,
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       ack,
   input wire logic       done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic take;
   logic go;
   logic cmd_ok_q;
   // a request is taken where req is up and no ack is pending
   assign take = req && !ack;
   assign go   = take && we && addr == 8'hf1 && wdata[1:0] == 2'h3;
   // last command written, so a refused start is told from a real one
   always_ff @(posedge sys_clk) begin
      if (rst)
         cmd_ok_q <= 1'b0;
      else if (take && we && addr == 8'hf0)
         cmd_ok_q <= wdata == 8'h35 || wdata == 8'h36;
   end
   property p_ack_pulse;    ack |=> !ack; endproperty
   property p_ack_next;     take |=> ack; endproperty
   property p_ack_cause;    ack |-> $past(req); endproperty
   property p_done_pulse;   done |=> !done; endproperty
   property p_start_done;   go && cmd_ok_q |-> ##[20:400] done; endproperty
   property p_done_cmd;     done |-> cmd_ok_q; endproperty
   property p_req_hold;
      take |=> req && $stable(addr) && $stable(we) && $stable(wdata);
   endproperty
   property p_rdata_hold;   $changed(rdata) |-> ack; endproperty
   a_ack_pulse:  assert property (p_ack_pulse) else $error("ack too long");
   a_ack_next:   assert property (p_ack_next) else $error("ack late");
   a_ack_cause:  assert property (p_ack_cause) else $error("stray ack");
   a_done_pulse: assert property (p_done_pulse) else $error("done long");
   a_start_done: assert property (p_start_done) else $error("no done");
   a_done_cmd:   assert property (p_done_cmd) else $error("bad done");
   a_req_hold:   assert property (p_req_hold) else $error("req moved");
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   c_start: cover property (go && cmd_ok_q);
   c_done:  cover property (done);
   c_read:  cover property (take && !we && addr == 8'hf4);
endmodule

// ### tb/tb_challenge_response_auth_memory.sv
/*
 * top bench: apb stimulus to the controller, otp bytes to the device,
 * digest comparisons between runs.
 * assumes both ends share sys_clk and a synchronous active-high rst.
 */
`timescale 1ns/1ps
module tb_challenge_response_auth_memory;
   logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [7:0]   otp_s, otp_i, c;
   logic [255:0] d0, d1, d2;
   logic [159:0] ch;
   int           n_mismatch, total_checks, seed;
   auth_link_if lk ();
   auth_host i_auth_host (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .lk(lk));
   auth_device i_auth_device (.sys_clk(sys_clk), .rst(rst), .lk(lk),
      .otp_secret_byte(otp_s), .otp_id_byte(otp_i), .engine_busy());
   auth_link_props i_auth_link_props (.sys_clk(sys_clk), .rst(rst),
      .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
      .rdata(lk.rdata), .ack(lk.ack), .done(lk.done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one apb transfer; read data lands in rd at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         check(32'h0, 32'h1);
      if (k >= 50)
         complete_run();
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // whole authentication through the controller's fixed sequence
   task automatic run(input logic [7:0] cm, output logic [255:0] dg);
      int k;
      for (int i = 0; i < 5; i++)
         apb(1'b1, 12'h020 + 12'(4 * i), ch[159 - 32 * i -: 32]);
      apb(1'b1, 12'h004, {24'h0, cm});
      apb(1'b1, 12'h000, 32'h1);
      for (k = 0; k < 3000 && irq !== 1'b1; k++)
         @(posedge sys_clk);
      if (irq !== 1'b1)
         check(32'h0, 32'h1);
      if (irq !== 1'b1)
         complete_run();
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, 32'h3);
      apb(1'b1, 12'h00c, 32'h3);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
         dg[255 - 32 * i -: 32] = rd;
      end
      check({31'h0, irq}, 32'h0);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      seed = 32'h96ca4ab3;
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      otp_s = 8'ha5;
      otp_i = 8'h3c;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h35);
      apb(1'b0, 12'h100, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 12'h010, 32'h2);
      // same inputs give the same digest; command and otp bytes matter
      for (int t = 0; t < 3; t++) begin
         ch = {$random(seed), $random(seed), $random(seed), $random(seed),
               $random(seed)};
         run(8'h36, d0);
         run(8'h36, d1);
         check({31'h0, d1 === d0}, 32'h1);
         check({31'h0, d0[255:96] !== ch}, 32'h1);
         run(8'h35, d2);
         check({31'h0, d2 !== d0}, 32'h1);
         otp_i <= otp_i ^ (8'($random(seed)) | 8'h01);
         run(8'h36, d1);
         check({31'h0, d1 === d0}, 32'h1);
         run(8'h35, d1);
         check({31'h0, d1 !== d2}, 32'h1);
         otp_s <= otp_s ^ (8'($random(seed)) | 8'h01);
         run(8'h36, d1);
         check({31'h0, d1 !== d0}, 32'h1);
         $display("test %0d done", t);
      end
      // reserved code: start is refused, no done event, no interrupt
      apb(1'b1, 12'h010, 32'h1);
      c = 8'($random(seed));
      if (c == 8'h35 || c == 8'h36)
         c = 8'h00;
      apb(1'b1, 12'h004, {24'h0, c});
      apb(1'b1, 12'h000, 32'h1);
      repeat (400) @(posedge sys_clk);
      apb(1'b0, 12'h00c, 32'h0);
      check(rd & 32'h1, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("test reserved done");
      complete_run();
   end
endmodule
